// file: adc_model.sv
// Purpose: Behavioural converter model on the far side of the ADC handshake
// Assumes: Start is a one-cycle pulse; one conversion at a time
// Notes:   Data is held only around done; scrambled afterwards
`timescale 1ns/1ps
`default_nettype none
module adc_model
(
   input wire logic clk,
   input wire logic start,
   input wire logic [6:0] value,
   output logic done,
   output logic [6:0] sample
);
   initial done = 1'b0;
   initial sample = 7'h00;
   // Data settles well before done rises, then goes stale on purpose
   always @(posedge clk)
   begin
      if (start)
      begin
         sample <= value;
         repeat (4) @(posedge clk);
         done <= 1'b1;
         repeat (4) @(posedge clk);
         done <= 1'b0;
         sample <= ~value;
      end
   end
endmodule // adc_model
`default_nettype wire

// file: cfm_pkg.sv
// Purpose: Shared constants and types for the converter fault monitor and ADC control
// Assumes: 25 MHz core clock; analog comparators and the converter sit outside
// Notes:   Timing constants are given in their own unit and converted to cycles here
`default_nettype none
package cfm_pkg;
   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000; // Core clock rate
   localparam int OV_BLANK_US = 1000; // Overvoltage re-arm delay after soft start, 1 ms
   localparam int PG_QUAL_US = 3300; // Power good qualification time, 3.3 ms
   localparam int OV_BLANK_CYCLES = (CLK_HZ / 1_000_000) * OV_BLANK_US; // Shorter wait, exact here
   localparam int PG_QUAL_CYCLES = (CLK_HZ / 1_000_000) * PG_QUAL_US; // Longer wait, exact here
   localparam logic [1:0] SW_QUAL_EDGES = 2'h2; // Switching edges spanned before a fault counts
   localparam int OV_FIXED_FREQ_KHZ = 50; // Switching rate forced during overvoltage
   // ---------------------------------------------------------------
   // Sense limit select codes and levels
   // ---------------------------------------------------------------
   localparam logic [1:0] LIMIT_SEL_250MV = 2'h0; // Default
   localparam logic [1:0] LIMIT_SEL_750MV = 2'h1;
   localparam logic [1:0] LIMIT_SEL_1500MV = 2'h2;
   localparam logic [1:0] LIMIT_SEL_2500MV = 2'h3;
   localparam int LIMIT_MV_DEFAULT = 250;
   // ---------------------------------------------------------------
   // ADC channel, trigger and scale
   // ---------------------------------------------------------------
   localparam int ADC_WIDTH = 7; // Result width, MSB at bit 6
   localparam logic [1:0] ADC_CH_FEEDBACK = 2'h0;
   localparam logic [1:0] ADC_CH_INPUT_RAIL = 2'h1;
   localparam logic [1:0] ADC_CH_SENSE_TWO = 2'h2;
   localparam logic [1:0] ADC_CH_SENSE_ONE = 2'h3;
   localparam logic [1:0] ADC_TRIG_FAULT = 2'h0; // Default: one read per fault
   localparam logic [1:0] ADC_TRIG_SINGLE = 2'h1;
   localparam logic [1:0] ADC_TRIG_CONT = 2'h2;
   localparam int ADC_LSB_MV = 20; // Per code at the mux
   localparam int ADC_FULL_MV = 2550; // Full span at the mux
   localparam int ADC_RAIL_LSB_MV = 200; // Per code on the rail after the 10:1 divider
   // ---------------------------------------------------------------
   // Reset values and status bit positions
   // ---------------------------------------------------------------
   localparam logic BULK_CAP_RESET = 1'h0; // Disengaged
   localparam logic PMOS_RESET = 1'h0; // Pulldown off
   localparam logic [3:0] STATUS_RESET = 4'h0;
   localparam int ST_OV = 0;
   localparam int ST_PG = 1;
   localparam int ST_THERM = 2;
   localparam int ST_EXTOC = 3;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sense_limit_sel_hi;
      logic sense_limit_sel_lo;
      logic oc_restart; // 1: trip restarts, 0: trip halts until reset
      logic overvoltage_mask;
      logic power_good_mask;
      logic thermal_mask;
      logic extoc_mask;
      logic int_show_pg;
      logic bulk_cap_switch_ctrl;
      logic pmos_drive_ctrl;
      logic [1:0] adc_channel;
      logic [1:0] adc_trigger;
   } cfg_t;
   typedef struct packed {
      logic all_off;
      logic buck_high_off;
      logic buck_low_on;
      logic boost_modulate;
      logic neg_limit_hold;
   } gate_ctrl_t;
   typedef enum logic [2:0] {TH_NORMAL = 3'h1, TH_HOT = 3'h2, TH_DISCHARGE = 3'h4} therm_state_t;
   typedef enum logic [2:0] {AD_IDLE = 3'h1, AD_START = 3'h2, AD_WAIT = 3'h4} adc_state_t;
endpackage
`default_nettype wire

// file: converter_fault_monitor_adc_ctrl.sv
// Purpose: Supervisory fault logic and ADC sequencing of a buck-boost controller
// Assumes: Settings arrive as a held configuration word; analog results arrive on pins
// Notes:   All pin inputs are synchronised; outputs are registered except the two tied-low open-drain data outputs
//
// What this block does
// - Comparator trip halts converter or restarts it
// - Either trip drives open-drain overcurrent flag
// - Overvoltage set after one full switching cycle
// - Overvoltage: buck high off, low on, boost discharges
// - Overvoltage forces fixed 50 kHz switching
// - Overvoltage blanked in transitions, armed 1 ms after soft start
// - Overvoltage mask hides action and indication
// - Power good after 3.3 ms inside window
// - Power good cleared after one cycle outside
// - Interrupt pin shows power good when configured
// - Power good mask hides status and interrupt, not POWER_GOOD
// - Thermal trip: all switches off, record, interrupt
// - Cooled after trip: discharge output to zero
// - Bulk cap drive from host bit, disengaged
// - P-channel pulldown from host bit, default off
// - Seven-bit result, MSB at bit six
// - Channel select routes the ADC mux
// - 20 mV per code, 200 mV on rails
// - Trigger 00 on fault, 01 on request
// - Trigger 10 converts continuously
`timescale 1ns/1ps
`default_nettype none
module converter_fault_monitor_adc_ctrl
#(
   parameter int PG_QUAL_CYCLES_P = cfm_pkg::PG_QUAL_CYCLES,
   parameter int OV_BLANK_CYCLES_P = cfm_pkg::OV_BLANK_CYCLES,
   parameter int ADC_BITS = cfm_pkg::ADC_WIDTH
)
(
   input wire logic CORE_CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire cfm_pkg::cfg_t CFG,
   input wire logic [3:0] STATUS_CLEAR,
   input wire logic ADC_REQ,
   input wire logic SENSE_ONE_TRIP,
   input wire logic SENSE_TWO_TRIP,
   input wire logic OV_COMPARE,
   input wire logic PG_INSIDE_NARROW,
   input wire logic PG_OUTSIDE_WIDE,
   input wire logic THERMAL_TRIP,
   input wire logic THERMAL_COOL,
   input wire logic VOLTAGE_TRANSITION,
   input wire logic SOFT_START_DONE,
   input wire logic OUTPUT_AT_ZERO,
   input wire logic SW_CLK,
   input wire logic CHIP_EN,
   input wire logic ADC_DONE,
   input wire logic [ADC_BITS-1:0] ADC_SAMPLE,
   output logic [1:0] SENSE_LIMIT_LEVEL,
   output logic OVERCURRENT_FLAG_OUT_O,
   output logic OVERCURRENT_FLAG_OUT_OE,
   output logic CONVERTER_HALT,
   output logic RESTART_REQ,
   output cfm_pkg::gate_ctrl_t GATE_CTRL,
   output logic FIXED_FREQ_SEL,
   output logic DISCHARGE_OUT,
   output logic POWER_GOOD,
   output logic INT_OUT,
   output logic [3:0] STATUS,
   output logic BULK_CAP_GATE_OUT,
   output logic PMOS_DRIVE_O,
   output logic PMOS_DRIVE_OE,
   output logic [1:0] ADC_MUX_SEL,
   output logic ADC_START,
   output logic [ADC_BITS-1:0] ADC_RESULT
);
   import cfm_pkg::*;

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   // The result layout is fixed by the host map, so only seven bits serve
   if (ADC_BITS != ADC_WIDTH) $error("ADC_BITS must be seven");
   if (PG_QUAL_CYCLES_P < 2) $error("PG_QUAL_CYCLES_P too small");
   if (OV_BLANK_CYCLES_P < 2) $error("OV_BLANK_CYCLES_P too small");

   localparam int NPIN = 13 + ADC_BITS; // Pins that need synchronising
   localparam int PGW = $clog2(PG_QUAL_CYCLES_P + 1);
   localparam int OVW = $clog2(OV_BLANK_CYCLES_P + 1);

   // Rising edge of a level against its previous sample
   function automatic logic rose(input logic cur, input logic prev);
      rose = cur & ~prev;
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [NPIN-1:0] pin_raw; // Gathered asynchronous inputs
   logic [NPIN-1:0] pin_meta; // First stage, read only by the second
   logic [NPIN-1:0] pin_s; // Second stage, safe to use
   logic [NPIN-1:0] pin_d; // Previous safe sample, for edges
   assign pin_raw = {ADC_SAMPLE, ADC_DONE, CHIP_EN, SW_CLK, OUTPUT_AT_ZERO, SOFT_START_DONE,
                     VOLTAGE_TRANSITION, THERMAL_COOL, THERMAL_TRIP, PG_OUTSIDE_WIDE,
                     PG_INSIDE_NARROW, OV_COMPARE, SENSE_TWO_TRIP, SENSE_ONE_TRIP};

   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++)
      begin : g_sync
         // Two flops per pin, then one more to find edges
         always_ff @(posedge CORE_CLK)
         begin
            if (SRST)
            begin
               pin_meta[gi] <= 1'b0;
               pin_s[gi] <= 1'b0;
               pin_d[gi] <= 1'b0;
            end
            else if (CE)
            begin
               pin_meta[gi] <= pin_raw[gi];
               pin_s[gi] <= pin_meta[gi];
               pin_d[gi] <= pin_s[gi];
            end
         end
      end
   endgenerate

   logic s1_trip, s2_trip, ov_cmp, pg_in, pg_out, th_trip, th_cool, v_trans, ss_done, at_zero;
   logic sw_tick, chip_en_s, adc_done_rise, ss_done_rise;
   logic [ADC_BITS-1:0] sample_s;
   assign s1_trip = pin_s[0];
   assign s2_trip = pin_s[1];
   assign ov_cmp = pin_s[2];
   assign pg_in = pin_s[3];
   assign pg_out = pin_s[4];
   assign th_trip = pin_s[5];
   assign th_cool = pin_s[6];
   assign v_trans = pin_s[7];
   assign ss_done = pin_s[8];
   assign at_zero = pin_s[9];
   assign sw_tick = rose(pin_s[10], pin_d[10]); // One pulse per switching cycle
   assign chip_en_s = pin_s[11];
   assign adc_done_rise = rose(pin_s[12], pin_d[12]);
   assign ss_done_rise = rose(ss_done, pin_d[8]);
   assign sample_s = pin_s[NPIN-1:13];

   // ---------------------------------------------------------------
   // External overcurrent comparators
   // ---------------------------------------------------------------
   logic oc_any; // Either sense monitor above the selected limit
   assign oc_any = s1_trip | s2_trip;

   // Limit level, flag drive, halt and restart
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         SENSE_LIMIT_LEVEL <= LIMIT_SEL_250MV;
         OVERCURRENT_FLAG_OUT_OE <= 1'b0;
         CONVERTER_HALT <= 1'b0;
         RESTART_REQ <= 1'b0;
      end
      else if (CE)
      begin
         SENSE_LIMIT_LEVEL <= {CFG.sense_limit_sel_hi, CFG.sense_limit_sel_lo};
         OVERCURRENT_FLAG_OUT_OE <= oc_any;
         // Halt is sticky until the part is reset; restart pulses every other cycle while a trip holds
         RESTART_REQ <= oc_any & CFG.oc_restart & ~RESTART_REQ;
         if (oc_any && !CFG.oc_restart)
         begin
            CONVERTER_HALT <= 1'b1;
         end
      end
   end
   // Open-drain: the pin is only ever pulled low
   assign OVERCURRENT_FLAG_OUT_O = 1'b0;
   assign PMOS_DRIVE_O = 1'b0;

   // ---------------------------------------------------------------
   // Overvoltage arming and detection
   // ---------------------------------------------------------------
   logic ov_armed; // Detection allowed
   logic ov_blank_run; // Counting the delay after soft start
   logic [OVW-1:0] ov_blank_cnt;
   logic [1:0] ov_edges; // Switching edges seen with comparator high
   logic ov_fault;
   logic ov_active; // Fault with its response unmasked
   assign ov_active = ov_fault & ~CFG.overvoltage_mask;

   // Blanking: a slewing output would trip the comparator falsely
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         ov_armed <= 1'b0;
         ov_blank_run <= 1'b0;
         ov_blank_cnt <= '0;
      end
      else if (CE)
      begin
         if (v_trans || !chip_en_s)
         begin
            ov_armed <= 1'b0;
            ov_blank_run <= 1'b0;
         end
         else if (ss_done_rise)
         begin
            ov_blank_run <= 1'b1;
            ov_blank_cnt <= '0;
         end
         else if (ov_blank_run)
         begin
            if (ov_blank_cnt == OVW'(OV_BLANK_CYCLES_P - 1))
            begin
               ov_armed <= 1'b1;
               ov_blank_run <= 1'b0;
            end
            else
            begin
               ov_blank_cnt <= ov_blank_cnt + 1'b1;
            end
         end
      end
   end

   // Fault sets only once the comparator has stayed high across a full cycle
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         ov_edges <= 2'h0;
         ov_fault <= 1'b0;
      end
      else if (CE)
      begin
         // A slew that starts in the arming cycle must not let a fault through
         if (!ov_cmp || !ov_armed || v_trans)
         begin
            ov_edges <= 2'h0;
            ov_fault <= 1'b0;
         end
         else if (sw_tick && ov_edges != SW_QUAL_EDGES)
         begin
            ov_edges <= ov_edges + 2'h1;
         end
         else if (ov_edges == SW_QUAL_EDGES)
         begin
            ov_fault <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Power good window
   // ---------------------------------------------------------------
   logic [PGW-1:0] pg_timer;
   logic [1:0] pg_edges; // Switching edges seen outside the wide window
   logic pg_good;

   // Hysteresis: enter on the narrow window, leave on the wide one
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         pg_timer <= '0;
         pg_edges <= 2'h0;
         pg_good <= 1'b0;
      end
      else if (CE)
      begin
         if (!chip_en_s)
         begin
            pg_good <= 1'b0;
            pg_timer <= '0;
            pg_edges <= 2'h0;
         end
         else if (pg_out)
         begin
            pg_timer <= '0;
            if (pg_edges == SW_QUAL_EDGES)
            begin
               pg_good <= 1'b0;
            end
            else if (sw_tick)
            begin
               pg_edges <= pg_edges + 2'h1;
            end
         end
         else
         begin
            pg_edges <= 2'h0;
            if (!pg_in)
            begin
               pg_timer <= '0;
            end
            else if (!pg_good && pg_timer == PGW'(PG_QUAL_CYCLES_P - 1))
            begin
               pg_good <= 1'b1;
            end
            else if (!pg_good)
            begin
               pg_timer <= pg_timer + 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Thermal response
   // ---------------------------------------------------------------
   therm_state_t th_state;
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         th_state <= TH_NORMAL;
      end
      else if (CE)
      begin
         case (th_state)
            TH_NORMAL: if (th_trip) th_state <= TH_HOT;
            TH_HOT: if (th_cool) th_state <= TH_DISCHARGE;
            TH_DISCHARGE:
            begin
               if (th_trip) th_state <= TH_HOT;
               else if (at_zero) th_state <= TH_NORMAL;
            end
            default: th_state <= TH_NORMAL;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Status, interrupt and drive outputs
   // ---------------------------------------------------------------
   logic pg_good_d, ov_fault_d;
   logic [3:0] next_set; // Events that latch a status bit
   logic [3:0] mask_vec;
   always_comb
   begin
      next_set = 4'h0;
      next_set[ST_OV] = rose(ov_fault, ov_fault_d) & ~CFG.overvoltage_mask;
      next_set[ST_PG] = ~pg_good & pg_good_d & ~CFG.power_good_mask;
      next_set[ST_THERM] = (th_state == TH_NORMAL) & th_trip;
      next_set[ST_EXTOC] = oc_any & ~OVERCURRENT_FLAG_OUT_OE;
   end
   assign mask_vec = {CFG.extoc_mask, CFG.thermal_mask, CFG.power_good_mask, CFG.overvoltage_mask};

   // Sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         STATUS <= STATUS_RESET;
         pg_good_d <= 1'b0;
         ov_fault_d <= 1'b0;
      end
      else if (CE)
      begin
         STATUS <= (STATUS & ~STATUS_CLEAR) | next_set;
         pg_good_d <= pg_good;
         ov_fault_d <= ov_fault;
      end
   end

   // Drive outputs follow the internal state one cycle later
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         GATE_CTRL <= '0;
         FIXED_FREQ_SEL <= 1'b0;
         DISCHARGE_OUT <= 1'b0;
         POWER_GOOD <= 1'b0;
         INT_OUT <= 1'b0;
         BULK_CAP_GATE_OUT <= BULK_CAP_RESET;
         PMOS_DRIVE_OE <= PMOS_RESET;
         ADC_MUX_SEL <= ADC_CH_FEEDBACK;
      end
      else if (CE)
      begin
         GATE_CTRL.all_off <= (th_state == TH_HOT);
         GATE_CTRL.buck_high_off <= (th_state == TH_HOT) | ov_active;
         GATE_CTRL.buck_low_on <= ov_active & (th_state != TH_HOT);
         GATE_CTRL.boost_modulate <= ov_active & (th_state != TH_HOT);
         GATE_CTRL.neg_limit_hold <= ov_active;
         FIXED_FREQ_SEL <= ov_active;
         DISCHARGE_OUT <= (th_state == TH_DISCHARGE);
         POWER_GOOD <= pg_good;
         // Interrupt held during startup until power good qualifies
         INT_OUT <= (|(STATUS & ~mask_vec)) |
                    (CFG.int_show_pg & ~CFG.power_good_mask & ~pg_good);
         BULK_CAP_GATE_OUT <= CFG.bulk_cap_switch_ctrl;
         PMOS_DRIVE_OE <= CFG.pmos_drive_ctrl;
         ADC_MUX_SEL <= CFG.adc_channel;
      end
   end

   // ---------------------------------------------------------------
   // ADC sequencing
   // ---------------------------------------------------------------
   adc_state_t adc_state;
   logic fault_pend, req_pend, adc_go;
   assign adc_go = (CFG.adc_trigger == ADC_TRIG_FAULT && fault_pend) ||
                   (CFG.adc_trigger == ADC_TRIG_SINGLE && req_pend) ||
                   (CFG.adc_trigger == ADC_TRIG_CONT);

   // Pending triggers; a new one in the launch cycle is kept
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         fault_pend <= 1'b0;
         req_pend <= 1'b0;
      end
      else if (CE)
      begin
         fault_pend <= (|next_set) | (fault_pend & ~(adc_state == AD_IDLE && adc_go));
         req_pend <= ADC_REQ | (req_pend & ~(adc_state == AD_IDLE && adc_go));
      end
   end

   // One conversion per start; the code is 20 mV per step at the mux
   always_ff @(posedge CORE_CLK)
   begin
      if (SRST)
      begin
         adc_state <= AD_IDLE;
         ADC_START <= 1'b0;
         ADC_RESULT <= '0;
      end
      else if (CE)
      begin
         ADC_START <= 1'b0;
         case (adc_state)
            AD_IDLE:
            begin
               if (adc_go)
               begin
                  adc_state <= AD_START;
                  ADC_START <= 1'b1;
               end
            end
            AD_START: adc_state <= AD_WAIT;
            AD_WAIT:
            begin
               if (adc_done_rise)
               begin
                  ADC_RESULT <= sample_s;
                  adc_state <= AD_IDLE;
               end
            end
            default: adc_state <= AD_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_halt_sticky: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CONVERTER_HALT |=> CONVERTER_HALT) else $error("halt released without reset");
   a_flag_on_trip: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && oc_any |=> OVERCURRENT_FLAG_OUT_OE) else $error("flag not driven on trip");
   a_ov_qualified: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $rose(ov_fault) |-> $past(ov_edges) == SW_QUAL_EDGES) else $error("ov set too early");
   a_ov_armed_only: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $rose(ov_fault) |-> $past(ov_armed) && !$past(v_trans)) else $error("ov while blanked");
   a_ov_gate_resp: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && ov_active && th_state == TH_NORMAL |=> GATE_CTRL.buck_low_on && GATE_CTRL.buck_high_off
      && FIXED_FREQ_SEL) else $error("ov response missing");
   a_ov_mask_hides: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && CFG.overvoltage_mask |=> !FIXED_FREQ_SEL) else $error("masked ov acted");
   a_pg_timer_full: assert property (@(posedge CORE_CLK) disable iff (SRST)
      $rose(pg_good) |-> $past(pg_timer) == PGW'(PG_QUAL_CYCLES_P - 1)) else $error("pg early");
   a_therm_all_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && th_trip && th_state == TH_NORMAL ##1 CE && !STATUS_CLEAR[ST_THERM]
      |=> GATE_CTRL.all_off && STATUS[ST_THERM])
      else $error("thermal trip not handled");
   a_status_set_wins: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && next_set[ST_EXTOC] |=> STATUS[ST_EXTOC]) else $error("status event lost");
   a_adc_capture: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && adc_state == AD_WAIT && adc_done_rise |=> ADC_RESULT == $past(sample_s))
      else $error("adc result not captured");
   a_adc_continuous: assert property (@(posedge CORE_CLK) disable iff (SRST)
      CE && adc_state == AD_IDLE && CFG.adc_trigger == ADC_TRIG_CONT |=> ADC_START)
      else $error("continuous mode did not start");
endmodule // converter_fault_monitor_adc_ctrl
`default_nettype wire

// file: converter_fault_monitor_adc_ctrl_tb.sv
// Purpose: Self-checking bench for the fault monitor
// Assumes: Short qualification counts
// Notes:   Inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,e) begin n_compared++; if ((a)!==(e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module converter_fault_monitor_adc_ctrl_tb;
   import cfm_pkg::*;
   logic clk=0, srst=1, req=0, t1=0, t2=0, ovc=0, pgn=0, tt=0, tc=0, en=0, pgw=0, zr=0;
   logic oe, halt, ff, dis, pg, bulk, pm, go, done, intr, rreq, fo, po;
   logic [1:0] lvl, mux;
   logic [3:0] swc=0, stclr=0, st;
   logic [6:0] res, smp, val=7'h00;
   cfg_t cfg='0;
   gate_ctrl_t gc;
   int n_fail=0, n_compared=0;
   always #20 clk = ~clk;
   // Slow switching clock, eight core cycles a period
   always @(negedge clk) swc <= swc + 4'h1;
   converter_fault_monitor_adc_ctrl #(.PG_QUAL_CYCLES_P(20), .OV_BLANK_CYCLES_P(10)) dut
   (
      .CORE_CLK(clk), .SRST(srst), .CE(1'b1), .CFG(cfg), .STATUS_CLEAR(stclr), .ADC_REQ(req),
      .SENSE_ONE_TRIP(t1), .SENSE_TWO_TRIP(t2), .OV_COMPARE(ovc), .PG_INSIDE_NARROW(pgn),
      .PG_OUTSIDE_WIDE(pgw), .THERMAL_TRIP(tt), .THERMAL_COOL(tc), .VOLTAGE_TRANSITION(1'b0),
      .SOFT_START_DONE(en), .OUTPUT_AT_ZERO(zr), .SW_CLK(swc[2]), .CHIP_EN(en), .ADC_DONE(done),
      .ADC_SAMPLE(smp), .SENSE_LIMIT_LEVEL(lvl), .OVERCURRENT_FLAG_OUT_O(fo), .OVERCURRENT_FLAG_OUT_OE(oe),
      .CONVERTER_HALT(halt), .RESTART_REQ(rreq), .GATE_CTRL(gc), .FIXED_FREQ_SEL(ff), .DISCHARGE_OUT(dis),
      .POWER_GOOD(pg), .INT_OUT(intr), .STATUS(st), .BULK_CAP_GATE_OUT(bulk), .PMOS_DRIVE_O(po),
      .PMOS_DRIVE_OE(pm), .ADC_MUX_SEL(mux), .ADC_START(go), .ADC_RESULT(res)
   );
   adc_model u_adc (.clk(clk), .start(go), .value(val), .done(done), .sample(smp));
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Every code of the host fields reaches its mirror
   task t_cfg();
      for (int i = 0; i < 4; i++)
      begin
         {cfg.sense_limit_sel_hi, cfg.sense_limit_sel_lo} = 2'(i);
         cfg.adc_channel = 2'(i);
         {cfg.pmos_drive_ctrl, cfg.bulk_cap_switch_ctrl} = 2'(i);
         cyc(2);
         `CHK(lvl, 2'(i))
         `CHK(mux, 2'(i))
         `CHK(bulk, i[0])
         `CHK(pm, i[1])
      end
   endtask
   // Interrupt shows the startup wait, then a wide-window loss clears good
   task t_pg();
      cfg.int_show_pg = 1'b1;
      pgn = 1'b1;
      cyc(10);
      `CHK(pg, 1'b0)
      `CHK(intr, 1'b1)
      cyc(25);
      `CHK(pg, 1'b1)
      `CHK(intr, 1'b0)
      pgw = 1'b1;
      cyc(30);
      `CHK(pg, 1'b0)
      `CHK(st[ST_PG], 1'b1)
      pgw = 1'b0;
   endtask
   task t_ov();
      ovc = 1'b1;
      cyc(40);
      `CHK(gc.buck_high_off, 1'b1)
      `CHK(gc.buck_low_on, 1'b1)
      `CHK(ff, 1'b1)
      `CHK(st[ST_OV], 1'b1)
      ovc = 1'b0;
   endtask
   // Second comparator alone must raise flag and halt
   task t_oc();
      t2 = 1'b1;
      cyc(4);
      `CHK(oe, 1'b1)
      `CHK(halt, 1'b1)
      `CHK(st[ST_EXTOC], 1'b1)
      t2 = 1'b0;
      cyc(4);
      // Restart mode: a pulse three edges after the trip, low on the next
      cfg.oc_restart = 1'b1;
      t1 = 1'b1;
      cyc(3);
      `CHK(rreq, 1'b1)
      cyc(1);
      `CHK(rreq, 1'b0)
      t1 = 1'b0;
      cfg.oc_restart = 1'b0;
      cyc(4);
   endtask
   task t_th();
      tt = 1'b1;
      cyc(6);
      `CHK(gc.all_off, 1'b1)
      `CHK(st[ST_THERM], 1'b1)
      tt = 1'b0;
      tc = 1'b1;
      cyc(6);
      `CHK(dis, 1'b1)
      zr = 1'b1;
      cyc(6);
      `CHK(dis, 1'b0)
      zr = 1'b0;
   endtask
   // A fresh value proves the chosen trigger started a conversion
   task t_adc(input logic [1:0] trg, input logic [6:0] v);
      cfg.adc_trigger = trg;
      cyc(30);
      val = v;
      req = (trg == ADC_TRIG_SINGLE);
      t1 = (trg == ADC_TRIG_FAULT);
      cyc(1);
      req = 1'b0;
      cyc(3);
      t1 = 1'b0;
      for (int k = 0; k < 60 && res !== v; k++) cyc(1);
      `CHK(res, v)
   endtask
   // Host clear empties status and interrupt; enable low clears power good
   task t_end();
      stclr = 4'hf;
      cyc(1);
      stclr = 4'h0;
      cyc(2);
      `CHK(st, 4'h0)
      `CHK(intr, 1'b0)
      en = 1'b0;
      cyc(6);
      `CHK(pg, 1'b0)
   endtask
   task results();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      cyc(12);
      srst = 1'b0;
      // Trips stay quiet while enable is low so the flag cannot glitch
      en = 1'b1;
      cyc(2);
      `CHK(bulk, BULK_CAP_RESET)
      `CHK(pm, PMOS_RESET)
      `CHK(fo, 1'b0)
      `CHK(po, 1'b0)
      t_cfg();
      t_pg();
      t_ov();
      t_oc();
      t_th();
      t_adc(ADC_TRIG_FAULT, 7'h33);
      t_adc(ADC_TRIG_SINGLE, 7'h5a);
      t_adc(ADC_TRIG_CONT, 7'h2b);
      t_end();
      results();
   end
endmodule // converter_fault_monitor_adc_ctrl_tb
`default_nettype wire
